// ===== logic/eis_pkg.sv
// package for the execution / interrupt status fields of the program status word
// assumes one core clock and an asynchronous active-low reset
package eis_pkg;
  // =====================================================
  // field positions
  localparam int unsigned EIS_RCB_HI_MSB = 26;
  localparam int unsigned EIS_RCB_HI_LSB = 25;
  localparam int unsigned EIS_ISET_POS = 24;
  localparam int unsigned EIS_RCB_LO_MSB = 15;
  localparam int unsigned EIS_RCB_LO_LSB = 10;
  localparam int unsigned EIS_EXC_MSB = 5;
  // =====================================================
  // reset values
  localparam logic [1:0] EIS_RCB_HI_RST = 2'h0;
  localparam logic [5:0] EIS_RCB_LO_RST = 6'h00;
  localparam logic EIS_ISET_RST = 1'b1;
  localparam logic [5:0] EIS_EXC_RST = 6'h00;
  // =====================================================
  // exception numbers
  localparam logic [5:0] EIS_EXC_THREAD = 6'h00;
  localparam logic [5:0] EIS_EXC_NMI = 6'h02;
  localparam logic [5:0] EIS_EXC_HARD = 6'h03;
  localparam logic [5:0] EIS_EXC_MEM = 6'h04;
  localparam logic [5:0] EIS_EXC_BUS = 6'h05;
  localparam logic [5:0] EIS_EXC_USAGE = 6'h06;
  localparam logic [5:0] EIS_EXC_SVC = 6'h0B;
  localparam logic [5:0] EIS_EXC_PENDSERV = 6'h0E;
  localparam logic [5:0] EIS_EXC_TICK = 6'h0F;
  localparam logic [5:0] EIS_EXC_IRQ_FIRST = 6'h10;
  localparam logic [5:0] EIS_EXC_IRQ_LAST = 6'h3B;
  // =====================================================
  // status-register read views
  typedef enum logic [1:0] {
    EIS_VIEW_FULL = 2'b00,
    EIS_VIEW_EXEC = 2'b01,
    EIS_VIEW_INTR = 2'b10,
    EIS_VIEW_APP = 2'b11
  } eis_view_e;
  // mode of the execution-state field
  typedef enum logic [1:0] {
    EIS_ST_IDLE = 2'b00,
    EIS_ST_RESUME = 2'b01,
    EIS_ST_CONDBLK = 2'b10
  } eis_state_e;

  // legal active-exception numbers only
  function automatic logic eis_exc_legal(input logic [5:0] n);
    eis_exc_legal = (n == EIS_EXC_THREAD) || ((n >= EIS_EXC_NMI) && (n <= EIS_EXC_USAGE)) ||
      (n == EIS_EXC_SVC) || (n == EIS_EXC_PENDSERV) || (n == EIS_EXC_TICK) ||
      ((n >= EIS_EXC_IRQ_FIRST) && (n <= EIS_EXC_IRQ_LAST));
  endfunction : eis_exc_legal
endpackage : eis_pkg

// ===== logic/eis_status_fields.sv
// execution-state and active-exception fields of the combined status word
// assumes the core pulses its event inputs for one cycle; reads are combinational views
// assumes every event input comes from core logic on ref_clk_in, so none is synchronised
// assumes at most one of pause, done, start and advance per cycle, ranked if not
// Notes on behaviour
// - resume/conditional-block state held at 26:25 and 15:10, both reset zero.
// - in resume mode bits 26:25 are forced to zero.
// - in resume mode bits 11:10 are zero; 15:12 hold the register number.
// - interrupt during a multiple transfer records next register in 15:12.
// - after service the transfer resumes at the saved register, not restarted.
// - up to four instructions after if-then form a tracked conditional block.
// - block instructions share a condition or its inverse, all conditional.
// - instruction-set state bit at 24, resets to one, read only.
// - exchange branches and pc pop load the bit from address bit zero.
// - exception return reloads the bit from the stacked status word.
// - exception entry and reset load the bit from vector bit zero.
// - executing with the bit clear raises a fault instead.
// - bits 5:0 give the active handler's exception number.
// - fields meaningful only through their proper views.
// - software reads of execution bits return zero; writes ignored.
// - software writes to the exception number are ignored.
`timescale 1ns/1ps
module eis_status_fields
  import eis_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // multiple-transfer events
  input wire logic xfer_irq_pause_in,
  input wire logic [3:0] xfer_next_reg_in,
  input wire logic xfer_resume_in,
  input wire logic xfer_done_in,
  // conditional-block events
  input wire logic condblk_start_in,
  input wire logic [7:0] condblk_state_in,
  input wire logic condblk_advance_in,
  // instruction-set state sources
  input wire logic branch_exchange_in,
  input wire logic [31:0] branch_target_in,
  input wire logic vector_load_in,
  input wire logic [31:0] vector_value_in,
  // exception entry and return
  input wire logic exc_entry_in,
  input wire logic [5:0] exc_number_in,
  input wire logic exc_return_in,
  input wire logic [31:0] stacked_status_in,
  input wire logic [5:0] return_number_in,
  input wire logic exec_attempt_in,
  // software status-register read
  input wire logic [1:0] sw_view_in,
  output logic [31:0] sw_read_out,
  // core-side outputs
  output logic [31:0] combined_status_out,
  output logic resume_valid_out,
  output logic [3:0] resume_reg_out,
  output logic condblk_active_out,
  output logic [3:0] condblk_cond_out,
  output logic exec_fault_out
);
  logic [1:0] rcb_hi_q, rcb_hi_d;
  logic [5:0] rcb_lo_q, rcb_lo_d;
  logic iset_q, iset_d;
  logic [5:0] exc_q, exc_d;
  logic fault_q;
  eis_state_e st_q, st_d;
  logic [7:0] stk_rcb;
  logic [7:0] blk_next;
  logic [7:0] blk_cur;
  logic stk_is_idle, stk_is_resume, blk_last;
  logic exc_entry_ok, exc_return_ok, view_shows_exc;
  logic [31:0] exec_bits, intr_bits;
  wire eis_view_e view = eis_view_e'(sw_view_in);

  // =====================================================
  // field layout of the combined word
  // 31:27 condition flags, not held here, read as zero
  // 26:25 upper piece of the resume or conditional-block state
  // 24 instruction-set state bit
  // 23:16 reserved, zero
  // 15:10 lower piece; in resume form 15:12 is the register, 11:10 zero
  // 9:6 reserved, zero
  // 5:0 active exception number

  // =====================================================
  // next-state decode
  // stacked field split back into hi/lo pieces on exception return
  assign stk_rcb = {stacked_status_in[EIS_RCB_HI_MSB:EIS_RCB_HI_LSB],
                    stacked_status_in[EIS_RCB_LO_MSB:EIS_RCB_LO_LSB]};
  // zero upper piece, zero bits 11:10 and nonzero 15:12 read back as a resume record; an if-then
  // state of that shape cannot be told apart, a limit of the shared encoding
  assign stk_is_idle = (stk_rcb == 8'h00);
  assign stk_is_resume = (stk_rcb[7:6] == 2'h0) && (stk_rcb[1:0] == 2'h0);
  // block state as {15:10, 26:25}: base condition on top, mask below it
  assign blk_cur = {rcb_lo_q, rcb_hi_q};
  // mask shifts left once per block instruction, base condition bits stay
  assign blk_next = {blk_cur[7:5], blk_cur[3:0], 1'b0};
  // low three bits clear marks the last of at most four block instructions
  assign blk_last = (blk_cur[2:0] == 3'h0);

  // return and pause outrank the per-state events; done only ends a resume record
  always_comb begin
    rcb_hi_d = rcb_hi_q;
    rcb_lo_d = rcb_lo_q;
    st_d = st_q;
    if (exc_return_in) begin
      // resumed from stacked word; resume form recognised by zero upper piece and zero low bits
      rcb_hi_d = stk_rcb[7:6];
      rcb_lo_d = stk_rcb[5:0];
      if (stk_is_idle) begin
        st_d = EIS_ST_IDLE;
      end else if (stk_is_resume) begin
        st_d = EIS_ST_RESUME;
      end else begin
        st_d = EIS_ST_CONDBLK;
      end
    end else if (xfer_irq_pause_in) begin
      rcb_hi_d = 2'h0;
      rcb_lo_d = {xfer_next_reg_in, 2'h0};
      st_d = EIS_ST_RESUME;
    end else begin
      unique case (st_q)
        EIS_ST_IDLE: begin
          if (condblk_start_in) begin
            rcb_hi_d = condblk_state_in[1:0];
            rcb_lo_d = condblk_state_in[7:2];
            st_d = EIS_ST_CONDBLK;
          end
        end
        EIS_ST_RESUME: begin
          if (xfer_done_in) begin
            rcb_hi_d = EIS_RCB_HI_RST;
            rcb_lo_d = EIS_RCB_LO_RST;
            st_d = EIS_ST_IDLE;
          end else if (condblk_start_in) begin
            rcb_hi_d = condblk_state_in[1:0];
            rcb_lo_d = condblk_state_in[7:2];
            st_d = EIS_ST_CONDBLK;
          end
        end
        EIS_ST_CONDBLK: begin
          if (condblk_start_in) begin
            // base condition plus mask; mask bits pick condition or inverse
            rcb_hi_d = condblk_state_in[1:0];
            rcb_lo_d = condblk_state_in[7:2];
          end else if (condblk_advance_in) begin
            if (blk_last) begin
              rcb_hi_d = EIS_RCB_HI_RST;
              rcb_lo_d = EIS_RCB_LO_RST;
              st_d = EIS_ST_IDLE;
            end else begin
              rcb_hi_d = blk_next[1:0];
              rcb_lo_d = blk_next[7:2];
            end
          end
        end
        default: begin
          // the one unused code falls back to an empty field
          rcb_hi_d = EIS_RCB_HI_RST;
          rcb_lo_d = EIS_RCB_LO_RST;
          st_d = EIS_ST_IDLE;
        end
      endcase
    end
  end

  // instruction-set bit: vector, stacked word, then branch target
  always_comb begin
    iset_d = iset_q;
    if (vector_load_in) begin
      iset_d = vector_value_in[0];
    end else if (exc_return_in) begin
      iset_d = stacked_status_in[EIS_ISET_POS];
    end else if (branch_exchange_in) begin
      iset_d = branch_target_in[0];
    end
  end

  // illegal numbers are dropped so the field never shows a reserved code
  assign exc_entry_ok = exc_entry_in && eis_exc_legal(exc_number_in);
  assign exc_return_ok = exc_return_in && eis_exc_legal(return_number_in);
  always_comb begin
    exc_d = exc_q;
    if (exc_entry_ok) begin
      exc_d = exc_number_in;
    end else if (exc_return_ok) begin
      exc_d = return_number_in;
    end
  end

  // =====================================================
  // state registers; no software write path exists at all
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rcb_hi_q <= EIS_RCB_HI_RST;
      rcb_lo_q <= EIS_RCB_LO_RST;
      iset_q <= EIS_ISET_RST;
      exc_q <= EIS_EXC_RST;
      st_q <= EIS_ST_IDLE;
      fault_q <= 1'b0;
    end else begin
      rcb_hi_q <= rcb_hi_d;
      rcb_lo_q <= rcb_lo_d;
      iset_q <= iset_d;
      exc_q <= exc_d;
      st_q <= st_d;
      // one-cycle flag; the core chooses between fault and lockup
      fault_q <= exec_attempt_in && !iset_q;
    end
  end

  // =====================================================
  // views; reserved bits 23:16 and 9:6 always zero
  assign exec_bits = {5'h00, rcb_hi_q, iset_q, 8'h00, rcb_lo_q, 10'h000};
  assign intr_bits = {26'h0000000, exc_q};
  assign combined_status_out = exec_bits | intr_bits;
  // software never sees execution bits; exception number only in full/intr view
  assign view_shows_exc = (view == EIS_VIEW_FULL) || (view == EIS_VIEW_INTR);
  assign sw_read_out = view_shows_exc ? intr_bits : 32'h00000000;
  assign resume_valid_out = (st_q == EIS_ST_RESUME);
  assign resume_reg_out = rcb_lo_q[5:2];
  assign condblk_active_out = (st_q == EIS_ST_CONDBLK);
  // current condition: base bits plus the mask bit that picks it or its inverse
  assign condblk_cond_out = blk_cur[7:4];
  assign exec_fault_out = fault_q;
endmodule : eis_status_fields

// ===== tb/eis_status_fields_asserts.sv
// checker for the execution-state and exception-number fields
// assumes it is bound to eis_status_fields: one clock, async active-low reset
`timescale 1ns/1ps
module eis_status_fields_asserts (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic xfer_irq_pause_in,
  input wire logic [3:0] xfer_next_reg_in,
  input wire logic branch_exchange_in,
  input wire logic [31:0] branch_target_in,
  input wire logic vector_load_in,
  input wire logic [31:0] vector_value_in,
  input wire logic exc_return_in,
  input wire logic [31:0] stacked_status_in,
  input wire logic exec_attempt_in,
  input wire logic [31:0] combined_status_out,
  input wire logic resume_valid_out,
  input wire logic [3:0] resume_reg_out,
  input wire logic exec_fault_out
);
  // =====================================================
  // properties: a return in the same cycle outranks a pause
  wire [31:0] c = combined_status_out;
  wire pz = xfer_irq_pause_in && !exc_return_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_hi; pz |=> c[26:25] == 2'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper state not zero");
  property p_lo; pz |=> c[11:10] == 2'h0 && c[15:12] == $past(xfer_next_reg_in); endproperty
  a_lo: assert property (p_lo) else $error("resume field wrong");
  property p_res; pz |=> resume_valid_out && resume_reg_out == $past(xfer_next_reg_in); endproperty
  a_res: assert property (p_res) else $error("resume reg wrong");
  property p_vec; vector_load_in |=> c[24] == $past(vector_value_in[0]); endproperty
  a_vec: assert property (p_vec) else $error("vector bit wrong");
  property p_ret; exc_return_in && !vector_load_in |=> c[24] == $past(stacked_status_in[24]); endproperty
  a_ret: assert property (p_ret) else $error("return bit wrong");
  property p_bx; branch_exchange_in && !vector_load_in && !exc_return_in |=> c[24] == $past(branch_target_in[0]); endproperty
  a_bx: assert property (p_bx) else $error("branch bit wrong");
  property p_flt; exec_attempt_in |=> exec_fault_out == !$past(c[24]); endproperty
  a_flt: assert property (p_flt) else $error("fault wrong");
  property p_rsv; !(c[5:0] inside {1, [7:10], 12, 13, [60:63]}); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved number");
endmodule : eis_status_fields_asserts
bind eis_status_fields eis_status_fields_asserts u_chk (
  .ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in),
  .xfer_irq_pause_in(xfer_irq_pause_in),
  .xfer_next_reg_in(xfer_next_reg_in),
  .branch_exchange_in(branch_exchange_in),
  .branch_target_in(branch_target_in),
  .vector_load_in(vector_load_in),
  .vector_value_in(vector_value_in),
  .exc_return_in(exc_return_in),
  .stacked_status_in(stacked_status_in),
  .exec_attempt_in(exec_attempt_in),
  .combined_status_out(combined_status_out),
  .resume_valid_out(resume_valid_out),
  .resume_reg_out(resume_reg_out),
  .exec_fault_out(exec_fault_out)
);

// ===== tb/tb.sv
// random core events checked against an integer model of the fields
// assumes eis_status_fields clocked at 200 MHz; one event pulse per cycle
`timescale 1ns/1ps
module tb;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic xfer_irq_pause_in, xfer_resume_in, xfer_done_in, condblk_start_in, condblk_advance_in;
  logic branch_exchange_in, vector_load_in, exc_entry_in, exc_return_in, exec_attempt_in;
  logic [3:0] xfer_next_reg_in, resume_reg_out, condblk_cond_out;
  logic [7:0] condblk_state_in;
  logic [31:0] branch_target_in, vector_value_in, stacked_status_in, sw_read_out;
  logic [31:0] combined_status_out;
  logic [5:0] exc_number_in, return_number_in;
  logic [1:0] sw_view_in;
  logic resume_valid_out, condblk_active_out, exec_fault_out;
  int seed = 50097, bad_count = 0, n_checks = 0, cyc = 0;
  int iset = 1, exc = 0, flt = 0, psd = 0, nreg = 0;
  // model state as {15:10, 26:25}; mode 0 idle, 1 resume, 2 block
  int rs = 0, md = 0;
  eis_status_fields dut (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .xfer_irq_pause_in(xfer_irq_pause_in),
    .xfer_next_reg_in(xfer_next_reg_in),
    .xfer_resume_in(xfer_resume_in),
    .xfer_done_in(xfer_done_in),
    .condblk_start_in(condblk_start_in),
    .condblk_state_in(condblk_state_in),
    .condblk_advance_in(condblk_advance_in),
    .branch_exchange_in(branch_exchange_in),
    .branch_target_in(branch_target_in),
    .vector_load_in(vector_load_in),
    .vector_value_in(vector_value_in),
    .exc_entry_in(exc_entry_in),
    .exc_number_in(exc_number_in),
    .exc_return_in(exc_return_in),
    .stacked_status_in(stacked_status_in),
    .return_number_in(return_number_in),
    .exec_attempt_in(exec_attempt_in),
    .sw_view_in(sw_view_in),
    .sw_read_out(sw_read_out),
    .combined_status_out(combined_status_out),
    .resume_valid_out(resume_valid_out),
    .resume_reg_out(resume_reg_out),
    .condblk_active_out(condblk_active_out),
    .condblk_cond_out(condblk_cond_out),
    .exec_fault_out(exec_fault_out)
  );
  always #2.5 ref_clk_in = ~ref_clk_in;
  // =====================================================
  // helpers; illegal numbers are sent on purpose and must be refused
  function automatic bit ok(int n);
    return !(n inside {1, [7:10], 12, 13, [60:63]});
  endfunction : ok
  task automatic drive(input logic [31:0] v);
    xfer_irq_pause_in <= v[3:0] == 4'h1;
    xfer_done_in <= v[3:0] == 4'h2;
    condblk_start_in <= v[3:0] == 4'h3;
    condblk_advance_in <= v[3:0] == 4'h4;
    branch_exchange_in <= v[3:0] == 4'h5;
    vector_load_in <= v[3:0] == 4'h6;
    exc_entry_in <= v[3:0] == 4'h7;
    exc_return_in <= v[3:0] == 4'h8;
    xfer_resume_in <= v[3:0] == 4'h9;
    exec_attempt_in <= v[4];
    sw_view_in <= v[6:5];
    xfer_next_reg_in <= v[10:7];
    {exc_number_in, return_number_in} <= v[22:11];
    condblk_state_in <= v[30:23];
    branch_target_in <= $random(seed);
    vector_value_in <= $random(seed);
    stacked_status_in <= $random(seed);
  endtask : drive
  task automatic chk(input string n, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // =====================================================
  // hang guard, well above the 3000-cycle run
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  // main run: compare, then let the model take the inputs sampled now
  initial begin
    drive(32'h0);
    repeat (10) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    chk("reset", combined_status_out, 32'h01000000);
    repeat (3000) begin
      @(posedge ref_clk_in);
      chk("word", combined_status_out & 32'h0100003F, (iset << 24) | exc);
      chk("view", sw_read_out & 32'h0700FC3F, sw_view_in[0] ? 0 : exc);
      chk("fault", {31'h0, exec_fault_out}, flt);
      if (psd)
        chk("resume", {19'h0, combined_status_out[26:25], combined_status_out[15:10],
          resume_valid_out, resume_reg_out}, {21'h0, nreg[3:0], 3'h1, nreg[3:0]});
      chk("state", {combined_status_out[15:10], combined_status_out[26:25]}, rs);
      chk("rsvd", combined_status_out & 32'hF8FF03C0, 0);
      chk("mode", {resume_valid_out, condblk_active_out}, {md == 1, md == 2});
      chk("cond", condblk_cond_out, rs[7:4]);
      chk("rreg", resume_reg_out, rs[7:4]);
      flt = exec_attempt_in && !iset;
      psd = xfer_irq_pause_in;
      nreg = xfer_next_reg_in;
      if (vector_load_in) iset = vector_value_in[0];
      else if (exc_return_in) iset = stacked_status_in[24];
      else if (branch_exchange_in) iset = branch_target_in[0];
      if (exc_return_in && ok(return_number_in)) exc = return_number_in;
      else if (exc_entry_in && !exc_return_in && ok(exc_number_in)) exc = exc_number_in;
      // resume and block state: return, pause, done, start, then advance
      if (exc_return_in) begin
        rs = {stacked_status_in[15:10], stacked_status_in[26:25]};
        md = (rs == 0) ? 0 : ((rs[3:0] == 0) ? 1 : 2);
      end else if (xfer_irq_pause_in) begin
        rs = {xfer_next_reg_in, 4'h0};
        md = 1;
      end else if (xfer_done_in && md == 1) begin
        rs = 0;
        md = 0;
      end else if (condblk_start_in) begin
        rs = condblk_state_in;
        md = 2;
      end else if (condblk_advance_in && md == 2) begin
        md = (rs[2:0] == 0) ? 0 : 2;
        rs = (rs[2:0] == 0) ? 0 : {rs[7:5], rs[3:0], 1'b0};
      end
      drive($random(seed));
    end
    close_out();
  end
endmodule : tb
